// *** design/its_sequencer.sv ***
// Purpose: input triggered state sequencer for four actuator columns
// Assumes: input lines asynchronous, register port on the same clock
// Notes: one trigger may wait while a state is being issued
`default_nettype none
module its_sequencer (
  input wire logic clock,
  input wire logic rst,
  input wire logic [its_pkg::ITS_LINES-1:0] in_lines,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output its_pkg::its_issue_s issue,
  output logic [5:0] cur_state,
  output logic busy
);
  import its_pkg::*;

  // next state of the sequence for a command, bit 6 says move
  function automatic logic [6:0] its_step(input logic [2:0] cmd,
                                          input logic [5:0] tgt,
                                          input logic [5:0] cur);
    logic [6:0] r;
    r = {1'b0, cur};
    case (cmd)
      ITS_CMD_NEXT: r = {1'b1, 6'(cur + 6'h01)};
      ITS_CMD_PREV: r = {1'b1, 6'(cur - 6'h01)};
      ITS_CMD_REPEAT: r = {1'b1, cur};
      ITS_CMD_GOTO: r = {1'b1, tgt};
      default: r = {1'b0, cur};
    endcase
    return r;
  endfunction : its_step

  logic [15:0] ctrl;
  logic [7:0] tbl_addr;
  its_entry_s cmd_tbl [16];
  logic [ITS_ROWS-1:0] row_def;
  logic [ITS_LINES-1:0] lvl;
  logic [ITS_LINES-1:0] chg;
  logic [3:0] combo;
  logic run;
  logic [3:0] in_en;
  logic [3:0] trig_en;
  logic [3:0] init_en;
  logic trig_fire;
  logic pend;
  logic take;
  its_entry_s ent;
  logic [6:0] step;
  its_fsm_e fsm;
  logic [1:0] col;
  logic [7:0] seq_addr;
  its_action_s seq_q;
  its_action_s bus_q;
  logic tbl_wr;
  logic [5:0] take_target;

  // line synchroniser and edge finder
  its_in_sync u_sync (
    .clock(clock),
    .rst(rst),
    .pins(in_lines),
    .level(lvl),
    .change(chg)
  );

  // state table storage
  its_state_mem u_mem (
    .clock(clock),
    .wr_en(tbl_wr),
    .wr_addr(tbl_addr),
    .wr_data(its_action_s'(wdata)),
    .rd_a_addr(seq_addr),
    .rd_a_data(seq_q),
    .rd_b_addr(tbl_addr),
    .rd_b_data(bus_q)
  );

  // control fields
  assign run = ctrl[ITS_CTRL_RUN];
  assign in_en = ctrl[ITS_CTRL_INEN +: 4];
  assign trig_en = ctrl[ITS_CTRL_TRIG +: 4];
  assign init_en = ctrl[ITS_CTRL_INIT +: 4];

  // combination from enabled lines, bit 0 is line A
  assign combo = lvl & in_en;

  // trigger decision, gated by run unless line is an init trigger
  always_comb begin
    logic [3:0] hits;
    hits = chg & in_en & trig_en;
    if (run) begin
      trig_fire = |hits;
    end else begin
      trig_fire = |(hits & init_en);
    end
  end

  // command lookup for the present combination
  assign take = (fsm == ITS_IDLE) && pend;
  assign ent = cmd_tbl[combo];
  assign step = its_step(ent.cmd, ent.target, cur_state);
  assign take_target = ent.target;
  assign seq_addr = {cur_state, col};
  assign tbl_wr = wr && (addr == ITS_REG_TBL_DATA);

  // pending trigger, a new edge wins over consumption
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
    end else begin
      pend <= trig_fire | (pend & ~take);
    end
  end

  // sequencer: choose state, then walk the actuator columns
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fsm <= ITS_IDLE;
      cur_state <= 6'h00;
      col <= 2'h0;
    end else begin
      case (fsm)
        ITS_IDLE: begin
          if (take && step[6]) begin
            cur_state <= step[5:0];
            col <= 2'h0;
            fsm <= ITS_FETCH;
          end
        end
        ITS_FETCH: begin
          fsm <= ITS_ISSUE;
        end
        ITS_ISSUE: begin
          col <= 2'(col + 2'h1);
          if (col == 2'(ITS_AXES - 1)) begin
            fsm <= ITS_IDLE;
          end else begin
            fsm <= ITS_FETCH;
          end
        end
        default: begin
          fsm <= ITS_IDLE;
        end
      endcase
    end
  end

  // action issue for defined rows and non-empty fields
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      issue <= '0;
    end else begin
      issue.valid <= 1'b0;
      if (fsm == ITS_ISSUE && row_def[cur_state] &&
          seq_q.op != ITS_OP_NOP) begin
        issue.valid <= 1'b1;
        issue.axis <= col;
        issue.row <= cur_state;
        issue.act <= seq_q;
      end
    end
  end

  // busy flag for software and the outside
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (fsm != ITS_IDLE) || (take && step[6]);
    end
  end

  // control and table address registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= ITS_CTRL_RST;
      tbl_addr <= 8'h00;
    end else if (wr) begin
      if (addr == ITS_REG_CTRL) begin
        ctrl <= wdata[15:0];
      end else if (addr == ITS_REG_TBL_ADDR) begin
        tbl_addr <= wdata[7:0];
      end else if (addr == ITS_REG_TBL_DATA) begin
        tbl_addr <= 8'(tbl_addr + 8'h01);
      end
    end
  end

  // rows become defined once any field is written
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      row_def <= '0;
    end else if (tbl_wr) begin
      row_def[tbl_addr[7:2]] <= 1'b1;
    end
  end

  // command table writes, one word per combination
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        cmd_tbl[i] <= '0;
      end
    end else if (wr && addr >= ITS_REG_CMD_BASE &&
                 addr <= ITS_REG_CMD_LAST && addr[1:0] == 2'h0) begin
      cmd_tbl[addr[5:2]].cmd <= wdata[ITS_ENT_CMD +: 3];
      cmd_tbl[addr[5:2]].target <= wdata[ITS_ENT_TGT +: 6];
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      rdata <= 32'h0000_0000;
      if (addr == ITS_REG_CTRL) begin
        rdata[15:0] <= ctrl;
      end else if (addr == ITS_REG_STATUS) begin
        rdata[ITS_ST_STATE +: 6] <= cur_state;
        rdata[ITS_ST_COMBO +: 4] <= combo;
        rdata[ITS_ST_BUSY] <= busy;
        rdata[ITS_ST_ROWDEF] <= row_def[cur_state];
        rdata[ITS_ST_PEND] <= pend;
      end else if (addr == ITS_REG_TBL_ADDR) begin
        rdata[7:0] <= tbl_addr;
      end else if (addr == ITS_REG_TBL_DATA) begin
        rdata <= bus_q;
      end else if (addr >= ITS_REG_CMD_BASE &&
                   addr <= ITS_REG_CMD_LAST && addr[1:0] == 2'h0) begin
        rdata[ITS_ENT_CMD +: 3] <= cmd_tbl[addr[5:2]].cmd;
        rdata[ITS_ENT_TGT +: 6] <= cmd_tbl[addr[5:2]].target;
      end
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_RUN_GATE: assert property (
    (!run && !pend && !(|(chg & in_en & trig_en & init_en)))
    |=> !pend)
    else $error("trigger accepted outside run");

  AST_TRIG_FIRES: assert property (
    (run && |(chg & in_en & trig_en)) |=> pend)
    else $error("trigger edge not taken");

  AST_NONTRIG_QUIET: assert property (
    (!pend && (chg & in_en & trig_en) == 4'h0) |=> !pend)
    else $error("non-trigger line launched a command");

  AST_NEXT: assert property (
    (take && ent.cmd == ITS_CMD_NEXT)
    |=> cur_state == 6'($past(cur_state) + 6'h01) && fsm == ITS_FETCH)
    else $error("next command did not advance");

  AST_PREV: assert property (
    (take && ent.cmd == ITS_CMD_PREV)
    |=> cur_state == 6'($past(cur_state) - 6'h01))
    else $error("previous command did not step back");

  AST_NOP_STAYS: assert property (
    (take && ent.cmd == ITS_CMD_NOP)
    |=> fsm == ITS_IDLE && $stable(cur_state))
    else $error("nop command moved the sequence");

  AST_GOTO: assert property (
    (take && ent.cmd == ITS_CMD_GOTO)
    |=> cur_state == $past(take_target) && fsm == ITS_FETCH)
    else $error("jump did not reach its target");

  AST_SWEEP_BOUND: assert property (
    (fsm == ITS_FETCH && col == 2'h0) |-> ##[7:7] fsm == ITS_ISSUE
    ##1 fsm == ITS_IDLE)
    else $error("actuator sweep length wrong");

  AST_NO_EMPTY_ISSUE: assert property (
    issue.valid |-> issue.act.op != ITS_OP_NOP && $past(fsm == ITS_ISSUE))
    else $error("empty field issued");

  COV_GOTO: cover property (take && ent.cmd == ITS_CMD_GOTO);
  COV_ISSUE: cover property (issue.valid && issue.axis == 2'h3);
  COV_PEND_BUSY: cover property (busy && trig_fire);
endmodule : its_sequencer
`default_nettype wire

// *** design/its_pkg.sv ***
// Purpose: shared constants and types of the input triggered sequencer
// Assumes: 100 MHz clock, four input lines, four actuator columns
// Notes: register offsets are byte addresses on the plain register port
`default_nettype none
package its_pkg;
  localparam int ITS_LINES = 4;
  localparam int ITS_ROWS = 64;
  localparam int ITS_AXES = 4;
  localparam int ITS_CLK_MHZ = 100;

  // register offsets
  localparam logic [7:0] ITS_REG_CTRL = 8'h00;
  localparam logic [7:0] ITS_REG_STATUS = 8'h04;
  localparam logic [7:0] ITS_REG_TBL_ADDR = 8'h08;
  localparam logic [7:0] ITS_REG_TBL_DATA = 8'h0C;
  localparam logic [7:0] ITS_REG_CMD_BASE = 8'h40;
  localparam logic [7:0] ITS_REG_CMD_LAST = 8'h7C;

  // control field positions and reset value
  localparam int ITS_CTRL_RUN = 0;
  localparam int ITS_CTRL_INEN = 4;
  localparam int ITS_CTRL_TRIG = 8;
  localparam int ITS_CTRL_INIT = 12;
  localparam logic [15:0] ITS_CTRL_RST = 16'h0000;

  // status field positions
  localparam int ITS_ST_STATE = 0;
  localparam int ITS_ST_COMBO = 8;
  localparam int ITS_ST_BUSY = 12;
  localparam int ITS_ST_ROWDEF = 13;
  localparam int ITS_ST_PEND = 14;

  // command table entry fields
  localparam int ITS_ENT_CMD = 0;
  localparam int ITS_ENT_TGT = 8;

  // commands of the command table
  localparam logic [2:0] ITS_CMD_NOP = 3'h0;
  localparam logic [2:0] ITS_CMD_NEXT = 3'h1;
  localparam logic [2:0] ITS_CMD_PREV = 3'h2;
  localparam logic [2:0] ITS_CMD_REPEAT = 3'h3;
  localparam logic [2:0] ITS_CMD_GOTO = 3'h4;

  // per actuator actions
  localparam logic [2:0] ITS_OP_NOP = 3'h0;
  localparam logic [2:0] ITS_OP_ABS = 3'h1;
  localparam logic [2:0] ITS_OP_REL = 3'h2;
  localparam logic [2:0] ITS_OP_CURVE = 3'h3;
  localparam logic [2:0] ITS_OP_STOP = 3'h4;
  localparam logic [2:0] ITS_OP_CURRENT = 3'h5;

  typedef struct packed {
    logic [2:0] op;
    logic [28:0] param;
  } its_action_s;

  typedef struct packed {
    logic [2:0] cmd;
    logic [5:0] target;
  } its_entry_s;

  typedef struct packed {
    logic valid;
    logic [1:0] axis;
    logic [5:0] row;
    its_action_s act;
  } its_issue_s;

  typedef enum logic [2:0] {
    ITS_IDLE = 3'b001,
    ITS_FETCH = 3'b010,
    ITS_ISSUE = 3'b100
  } its_fsm_e;
endpackage : its_pkg
`default_nettype wire

// *** design/its_in_sync.sv ***
// Purpose: synchronise the four input lines and flag level changes
// Assumes: pins are asynchronous to clock
// Notes: level and change are aligned and both registered
`default_nettype none
module its_in_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic [its_pkg::ITS_LINES-1:0] pins,
  output logic [its_pkg::ITS_LINES-1:0] level,
  output logic [its_pkg::ITS_LINES-1:0] change
);
  import its_pkg::*;

  logic [ITS_LINES-1:0] meta;
  logic [ITS_LINES-1:0] sync;
  logic [ITS_LINES-1:0] prev;

  // two stage synchroniser, first stage read only by second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= pins;
      sync <= meta;
    end
  end

  // compare present and previous sample
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev <= '0;
      level <= '0;
      change <= '0;
    end else begin
      prev <= sync;
      level <= sync;
      change <= sync ^ prev;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_CHANGE_IS_EDGE: assert property (
    change == (level ^ $past(level)))
    else $error("change flag does not match a level edge");
endmodule : its_in_sync
`default_nettype wire

// *** design/its_state_mem.sv ***
// Purpose: state table, one action word per row and actuator column
// Assumes: 64 rows of four columns, address is row then column
// Notes: port a reads on the clock, port b reads combinationally
`default_nettype none
module its_state_mem (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire its_pkg::its_action_s wr_data,
  input wire logic [7:0] rd_a_addr,
  output its_pkg::its_action_s rd_a_data,
  input wire logic [7:0] rd_b_addr,
  output its_pkg::its_action_s rd_b_data
);
  import its_pkg::*;

  its_action_s mem [ITS_ROWS*ITS_AXES];

  // table write and sequencer read
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_a_data <= mem[rd_a_addr];
  end

  // software read back
  assign rd_b_data = mem[rd_b_addr];
endmodule : its_state_mem
`default_nettype wire

// *** sim/its_master_model.sv ***
// Purpose: master control system driving the four input lines
// Assumes: lines are plain levels, no pull resistors
// Notes: levels change only right after a rising clock edge
`default_nettype none
module its_master_model (
  input wire logic clock,
  output logic [3:0] lines
);
  timeunit 1ns;
  timeprecision 1ns;

  // lines start low and hold each level until told otherwise
  initial lines = 4'h0;

  // new combination after an edge, bit0 is line a
  task automatic drive(input logic [3:0] v);
    @(posedge clock);
    lines <= v;
  endtask : drive
endmodule : its_master_model
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: self checking bench of the input triggered sequencer
// Assumes: issue pulses come within 30 cycles of a line change
// Notes: rows 0 and 5 defined, every other row left empty
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import its_pkg::*;

  logic clock = 1'b0;
  logic rst = 1'b1;
  wire logic [3:0] in_lines;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  its_issue_s issue;
  logic [5:0] cur_state;
  logic busy;
  int bad_count = 0;
  int checked = 0;
  logic [31:0] tw [8];
  logic [31:0] d;

  // clock and parts
  always #5 clock = ~clock;

  its_master_model i_master (.clock(clock), .lines(in_lines));

  its_sequencer i_dut (
    .clock(clock), .rst(rst), .in_lines(in_lines), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .issue(issue),
    .cur_state(cur_state), .busy(busy));

  task automatic results();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    checked++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  function automatic logic [31:0] ent(input logic [2:0] c,
                                      input logic [5:0] t);
    return {18'h0_0000, t, 5'h00, c};
  endfunction : ent

  // one line change, then count and judge the issued actions
  task automatic step(input logic [3:0] v, input logic [5:0] st,
                      input int n);
    int cnt;
    cnt = 0;
    i_master.drive(v);
    repeat (30) begin
      @(posedge clock);
      #1;
      if (issue.valid === 1'b1) begin
        cnt++;
        chk("issue row", 32'(st), 32'(issue.row));
        chk("issue act", tw[{issue.row == 6'h05, issue.axis}],
            32'(issue.act));
      end
    end
    chk("cur_state", 32'(st), 32'(cur_state));
    chk("issue count", 32'(n), 32'(cnt));
    if (busy !== 1'b0) begin
      chk("busy", 32'h0, 32'(busy));
      results();
    end
  endtask : step

  task automatic scn_reset();
    rd_reg(ITS_REG_CTRL, d);
    chk("ctrl", 32'(ITS_CTRL_RST), d);
    rd_reg(ITS_REG_STATUS, d);
    chk("status", 32'h0000_0000, d);
  endtask : scn_reset

  // state rows, command entries, refused accesses
  task automatic scn_tables();
    wr_reg(ITS_REG_TBL_ADDR, 32'h0000_0000);
    for (int c = 0; c < 4; c++) wr_reg(ITS_REG_TBL_DATA, tw[c]);
    wr_reg(ITS_REG_TBL_ADDR, 32'h0000_0014);
    for (int c = 4; c < 8; c++) wr_reg(ITS_REG_TBL_DATA, tw[c]);
    wr_reg(ITS_REG_TBL_ADDR, 32'h0000_0015);
    rd_reg(ITS_REG_TBL_DATA, d);
    chk("row 5 col 1", tw[5], d);
    wr_reg(ITS_REG_CMD_BASE + 8'h14, ent(ITS_CMD_GOTO, 6'h05));
    wr_reg(ITS_REG_CMD_BASE + 8'h10, ent(ITS_CMD_NEXT, 6'h00));
    wr_reg(ITS_REG_CMD_BASE + 8'h04, ent(ITS_CMD_PREV, 6'h00));
    wr_reg(ITS_REG_CMD_BASE + 8'h0C, ent(ITS_CMD_REPEAT, 6'h00));
    wr_reg(ITS_REG_CMD_BASE + 8'h08, ent(ITS_CMD_GOTO, 6'h00));
    wr_reg(ITS_REG_CMD_BASE + 8'h02, ent(ITS_CMD_GOTO, 6'h05));
    rd_reg(8'h20, d);
    chk("unmapped read", 32'h0000_0000, d);
  endtask : scn_tables

  // triggers ignored outside run, except lines set for init use
  task automatic scn_not_run();
    wr_reg(ITS_REG_CTRL, 32'h0000_0F30);
    step(4'h1, 6'h00, 0);
    step(4'h0, 6'h00, 0);
    wr_reg(ITS_REG_CTRL, 32'h0000_2F30);
    step(4'h1, 6'h00, 0);
    step(4'h3, 6'h00, 2);
    step(4'h0, 6'h00, 0);
  endtask : scn_not_run

  // run sequence through every command and the wrap
  task automatic scn_run();
    logic [3:0] tv [11] = '{4'h4, 4'h5, 4'h4, 4'h0, 4'h1, 4'h3,
                            4'h2, 4'h0, 4'h1, 4'h5, 4'h4};
    logic [5:0] ts [11] = '{6'h00, 6'h05, 6'h06, 6'h06, 6'h05, 6'h05,
                            6'h00, 6'h00, 6'h3F, 6'h3F, 6'h00};
    int tn [11] = '{0, 3, 0, 0, 3, 3, 2, 0, 0, 0, 2};
    // run, all four lines in the combination, only a and b trigger
    wr_reg(ITS_REG_CTRL, 32'h0000_03F1);
    step(tv[0], ts[0], tn[0]);
    rd_reg(ITS_REG_STATUS, d);
    chk("combination", 32'h0000_0004, 32'(d[11:8]));
    for (int i = 1; i < 11; i++) step(tv[i], ts[i], tn[i]);
  endtask : scn_run

  // line c disabled leaves it out of the combination
  task automatic scn_mask();
    wr_reg(ITS_REG_CTRL, 32'h0000_0B31);
    step(4'h5, 6'h3F, 0);
    rd_reg(ITS_REG_STATUS, d);
    chk("masked combination", 32'h0000_0001, 32'(d[11:8]));
  endtask : scn_mask

  // expected action words, then reset and scenarios
  initial begin
    tw[0] = {ITS_OP_STOP, 29'h0000_0011};
    tw[1] = {ITS_OP_CURRENT, 29'h0000_0022};
    tw[2] = {ITS_OP_NOP, 29'h0000_0033};
    tw[3] = {ITS_OP_NOP, 29'h0000_0000};
    tw[4] = {ITS_OP_ABS, 29'h0012_3456};
    tw[5] = {ITS_OP_REL, 29'h1FFF_FF00};
    tw[6] = {ITS_OP_NOP, 29'h0000_0000};
    tw[7] = {ITS_OP_CURVE, 29'h0000_0006};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    scn_reset();
    scn_tables();
    scn_not_run();
    scn_run();
    scn_mask();
    results();
  end
endmodule : tb_top
`default_nettype wire
